/* File: nor_host_ctrl.sv */
/*
  Host controller driving an asynchronous x16 NOR flash bus: random and page
  reads, command writes, hardware reset with wake-up wait, and status polling.
  Assumes the flash sits directly on the o_/i_ pins and a pull-up on ready_busy_n.
*/
// How it works
// - Read drives address, chip select and output enable low, write strobe high.
// - Write keeps output enable high, chip select and strobe low, reset high.
// - Address is set up before the later falling edge of select or strobe.
// - Data is held stable until the earlier rising edge of select or strobe.
// - After reset rises host waits read and write wake-up delays.
// - Host monitors operations with polling status and the ready/busy pin, never status register.
// - Status bit 1 set means abort; host must issue abort-reset sequence. Host only reports it in o_poll.aborted.
`timescale 1ns/100ps
module nor_host_ctrl #(
  parameter int unsigned ADDR_W = nor_host_pkg::ADDR_W,
  parameter int unsigned DATA_W = nor_host_pkg::DATA_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire nor_host_pkg::host_req_t i_req,
  input wire logic i_req_valid,
  output logic o_req_ready,
  output logic [DATA_W-1:0] o_rd_data,
  output nor_host_pkg::poll_result_t o_poll,
  output logic o_done,
  output logic o_contents_invalid,
  output logic o_busy_pin,
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic o_chip_select_n,
  output logic o_output_enable_n,
  output logic o_write_strobe_n,
  output logic o_hw_reset_n,
  output logic o_write_protect_n,
  output logic [DATA_W-1:0] o_dq_out,
  output logic o_dq_oe_n,
  input wire logic [DATA_W-1:0] i_dq_in,
  input wire logic i_ready_busy_n
);
  initial begin
    if (ADDR_W != nor_host_pkg::ADDR_W || DATA_W != nor_host_pkg::DATA_W) begin
      $error("nor_host_ctrl: unsupported bus widths");
    end
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_ACC = 4'h1,
    ST_RD_DONE = 4'h2,
    ST_WR_SETUP = 4'h3,
    ST_WR_PULSE = 4'h4,
    ST_WR_HOLD = 4'h5,
    ST_RST_LOW = 4'h6,
    ST_RST_WAIT = 4'h7,
    ST_POLL_A = 4'h8,
    ST_POLL_B = 4'h9,
    ST_GAP = 4'ha
  } state_t;

  state_t state_ff, nxt_state;
  logic [nor_host_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  nor_host_pkg::host_req_t req_ff, nxt_req;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic ce_n_ff, nxt_ce_n;
  logic oe_n_ff, nxt_oe_n;
  logic we_n_ff, nxt_we_n;
  logic rst_n_ff, nxt_rst_n;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic [DATA_W-1:0] dq_out_ff, nxt_dq_out;
  logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
  logic [DATA_W-1:0] first_ff, nxt_first;
  nor_host_pkg::poll_result_t poll_ff, nxt_poll;
  logic done_ff, nxt_done;
  logic page_valid_ff, nxt_page_valid;
  logic invalid_ff, nxt_invalid;
  logic busy_sync;

  nor_pin_sync #(.RESET_VAL(1'b1)) u_rb_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ready_busy_n),
    .o_level(busy_sync)
  );

  // Same page when all address bits above the page offset match the last read
  function automatic logic same_page(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:nor_host_pkg::PAGE_ADDR_W] == b[ADDR_W-1:nor_host_pkg::PAGE_ADDR_W];
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    nxt_req = req_ff;
    nxt_addr = addr_ff;
    nxt_ce_n = ce_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_we_n = we_n_ff;
    nxt_rst_n = rst_n_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    nxt_dq_out = dq_out_ff;
    nxt_rd_data = rd_data_ff;
    nxt_first = first_ff;
    nxt_poll = poll_ff;
    nxt_done = 1'b0;
    nxt_page_valid = page_valid_ff;
    nxt_invalid = invalid_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (i_req_valid) begin
          nxt_req = i_req;
          nxt_addr = i_req.addr;
          unique case (i_req.op)
            nor_host_pkg::CMD_READ: begin
              nxt_ce_n = 1'b0;
              nxt_oe_n = 1'b0;
              nxt_dq_oe_n = 1'b1;
              nxt_cnt = (page_valid_ff && !ce_n_ff && same_page(i_req.addr, addr_ff)) ?
                nor_host_pkg::CNT_W'(nor_host_pkg::PAGE_ACC_CYC) :
                nor_host_pkg::CNT_W'(nor_host_pkg::RANDOM_ACC_CYC);
              nxt_state = ST_RD_ACC;
            end
            nor_host_pkg::CMD_WRITE: begin
              // address and select settle before the strobe falls
              nxt_ce_n = 1'b0;
              nxt_oe_n = 1'b1;
              nxt_dq_out = i_req.data;
              nxt_dq_oe_n = 1'b0;
              nxt_page_valid = 1'b0;
              nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::SETUP_CYC);
              nxt_state = ST_WR_SETUP;
            end
            nor_host_pkg::CMD_POLL: begin
              nxt_ce_n = 1'b0;
              nxt_oe_n = 1'b0;
              nxt_dq_oe_n = 1'b1;
              nxt_page_valid = 1'b0;
              nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::RANDOM_ACC_CYC);
              nxt_state = ST_POLL_A;
            end
            default: begin
              nxt_ce_n = 1'b1;
              nxt_oe_n = 1'b1;
              nxt_we_n = 1'b1;
              nxt_dq_oe_n = 1'b1;
              nxt_rst_n = 1'b0;
              nxt_page_valid = 1'b0;
              // a reset while busy leaves the target contents undefined
              nxt_invalid = !busy_sync;
              nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::RESET_PULSE_CYC);
              nxt_state = ST_RST_LOW;
            end
          endcase
        end
      end
      ST_RD_ACC: begin
        if (cnt_ff == '0) begin
          nxt_rd_data = i_dq_in;
          nxt_page_valid = 1'b1;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE; // select stays low after every read until a later write, poll or reset raises it
        end
      end
      ST_WR_SETUP: begin
        if (cnt_ff == '0) begin
          nxt_we_n = 1'b0;
          nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::WRITE_PULSE_CYC);
          nxt_state = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (cnt_ff == '0) begin
          nxt_we_n = 1'b1; // data held past the strobe rise
          nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::SETUP_CYC);
          nxt_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (cnt_ff == '0) begin
          nxt_ce_n = 1'b1;
          nxt_dq_oe_n = 1'b1;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_RST_LOW: begin
        if (cnt_ff == '0) begin
          nxt_rst_n = 1'b1;
          nxt_cnt = nor_host_pkg::CNT_W'((nor_host_pkg::RESET_TO_READ_CYC >
            nor_host_pkg::RESET_TO_WRITE_CYC) ? nor_host_pkg::RESET_TO_READ_CYC :
            nor_host_pkg::RESET_TO_WRITE_CYC);
          nxt_state = ST_RST_WAIT;
        end
      end
      ST_RST_WAIT: begin
        if (cnt_ff == '0) begin
          nxt_poll = '0;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_POLL_A: begin
        if (cnt_ff == '0) begin
          nxt_first = i_dq_in;
          nxt_oe_n = 1'b1; // Each status read must be a fresh output-enable cycle
          nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::SETUP_CYC);
          nxt_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_ff == '0) begin
          nxt_oe_n = 1'b0;
          nxt_cnt = nor_host_pkg::CNT_W'(nor_host_pkg::RANDOM_ACC_CYC);
          nxt_state = ST_POLL_B;
        end
      end
      ST_POLL_B: begin
        if (cnt_ff == '0) begin
          nxt_rd_data = i_dq_in;
          // bit 7 equals written data only when done
          nxt_poll.done_poll = (i_dq_in[nor_host_pkg::ST_POLL_BIT] ==
            req_ff.data[nor_host_pkg::ST_POLL_BIT]) && (i_dq_in[15:8] == req_ff.data[15:8] ||
            i_dq_in[15:8] != nor_host_pkg::STATUS_UPPER);
          nxt_poll.toggling = i_dq_in[nor_host_pkg::ST_TOGGLE_BIT] !=
            first_ff[nor_host_pkg::ST_TOGGLE_BIT];
          nxt_poll.alt_toggling = i_dq_in[nor_host_pkg::ST_ALT_TOGGLE_BIT] !=
            first_ff[nor_host_pkg::ST_ALT_TOGGLE_BIT];
          nxt_poll.error = i_dq_in[nor_host_pkg::ST_ERROR_BIT];
          nxt_poll.erase_started = i_dq_in[nor_host_pkg::ST_ERASE_TIMER_BIT];
          nxt_poll.aborted = i_dq_in[nor_host_pkg::ST_ABORT_BIT];
          nxt_ce_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      req_ff <= '0;
      addr_ff <= '0;
      ce_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      rst_n_ff <= 1'b1;
      dq_oe_n_ff <= 1'b1;
      dq_out_ff <= '0;
      rd_data_ff <= '0;
      first_ff <= nor_host_pkg::STATUS_RESET;
      poll_ff <= '0;
      done_ff <= 1'b0;
      page_valid_ff <= 1'b0;
      invalid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      req_ff <= nxt_req;
      addr_ff <= nxt_addr;
      ce_n_ff <= nxt_ce_n;
      oe_n_ff <= nxt_oe_n;
      we_n_ff <= nxt_we_n;
      rst_n_ff <= nxt_rst_n;
      dq_oe_n_ff <= nxt_dq_oe_n;
      dq_out_ff <= nxt_dq_out;
      rd_data_ff <= nxt_rd_data;
      first_ff <= nxt_first;
      poll_ff <= nxt_poll;
      done_ff <= nxt_done;
      page_valid_ff <= nxt_page_valid;
      invalid_ff <= nxt_invalid;
    end
  end

  assign o_req_ready = (state_ff == ST_IDLE);
  assign o_rd_data = rd_data_ff;
  assign o_poll = poll_ff;
  assign o_done = done_ff;
  assign o_contents_invalid = invalid_ff;
  assign o_busy_pin = !busy_sync;
  assign o_flash_addr = addr_ff;
  assign o_chip_select_n = ce_n_ff;
  assign o_output_enable_n = oe_n_ff;
  assign o_write_strobe_n = we_n_ff;
  assign o_hw_reset_n = rst_n_ff;
  assign o_write_protect_n = 1'b1; // keep the top end block (10'h3ff) writable
  assign o_dq_out = dq_out_ff;
  assign o_dq_oe_n = dq_oe_n_ff;
endmodule

/* File: nor_host_pkg.sv */
/*
  Shared constants and carrier types for the parallel NOR flash host controller.
  Assumes a 50 MHz system clock and a x16 asynchronous flash on the far side.
*/
package nor_host_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BLOCK_ADDR_W = 16;
  localparam int unsigned BLOCK_NUM_W = 10;
  localparam int unsigned PAGE_ADDR_W = 4;
  localparam int unsigned GLITCH_NS = 3;
  localparam int unsigned RESET_TO_READ_NS = 150;
  localparam int unsigned RESET_TO_WRITE_NS = 150;
  localparam int unsigned RESET_PULSE_NS = 100;
  localparam int unsigned RANDOM_ACC_NS = 110;
  localparam int unsigned PAGE_ACC_NS = 20;
  localparam int unsigned WRITE_PULSE_NS = 50;
  localparam int unsigned SETUP_NS = 20;
  localparam int unsigned RESET_TO_READ_CYC =
    (RESET_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_TO_WRITE_CYC =
    (RESET_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RANDOM_ACC_CYC = (RANDOM_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAGE_ACC_CYC = (PAGE_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  // Polling status bit positions
  localparam int unsigned ST_POLL_BIT = 7;
  localparam int unsigned ST_TOGGLE_BIT = 6;
  localparam int unsigned ST_ERROR_BIT = 5;
  localparam int unsigned ST_ERASE_TIMER_BIT = 3;
  localparam int unsigned ST_ALT_TOGGLE_BIT = 2;
  localparam int unsigned ST_ABORT_BIT = 1;
  localparam logic [7:0] STATUS_UPPER = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CMD_READ = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_POLL = 2'h2,
    CMD_RESET = 2'h3
  } cmd_op_t;

  typedef struct packed {
    cmd_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_req_t;

  typedef struct packed {
    logic done_poll;
    logic toggling;
    logic alt_toggling;
    logic error;
    logic erase_started;
    logic aborted;
  } poll_result_t;

  function automatic logic [BLOCK_NUM_W-1:0] block_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLOCK_ADDR_W];
  endfunction
endpackage

/* File: nor_pin_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one asynchronous pin.
  Assumes the pin is not related to i_sys_clk.
*/
`timescale 1ns/100ps
module nor_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level
);
  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic level_ff;
  logic nxt_level;

  always_comb begin
    nxt_sync = {sync_ff[1:0], i_pin};
    // Only stages two and three are looked at; stage one feeds stage two alone
    nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_ff <= {3{RESET_VAL}};
      level_ff <= RESET_VAL;
    end else begin
      sync_ff <= nxt_sync;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;
endmodule

/* File: nor_flash_model.sv */
/* Behavioural x16 NOR flash with polling status word, answering the host pins.
   Assumes the bench resolves the shared data bus; times are in ns. */
`timescale 1ns/100ps
module nor_flash_model #(
  parameter int ACC_NS = 15,
  parameter int BUSY_NS = 4000,
  parameter logic [9:0] FAIL_BLK = 10'h155
) (
  input wire logic [25:0] i_addr,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_rst_n,
  input wire logic i_wp_n,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_ready_busy_n
);
  logic [15:0] mem [logic [25:0]];
  logic [15:0] prog_data = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] out_val;
  logic [25:0] wa = 26'h0000000;
  logic tog = 1'b0;
  logic err_mode = 1'b0;
  logic rd_act;
  logic wr_act;
  int busy_cnt = 0;
  assign rd_act = !i_ce_n && !i_oe_n && i_we_n && i_rst_n;
  assign wr_act = !i_ce_n && !i_we_n && i_oe_n && i_rst_n;
  // Status replaces array data at every address while busy or failed
  always @* begin
    if (busy_cnt != 0 || err_mode)
      out_val = {8'h00, ~prog_data[7], tog, err_mode, 5'h00};
    else if (mem.exists(i_addr))
      out_val = mem[i_addr];
    else
      out_val = i_addr[15:0] ^ {6'h00, i_addr[25:16]};
  end
  // A released bus shows the inverse of the last word, never a held value
  assign #(ACC_NS) o_dq = rd_act ? out_val : ~last_q;
  assign o_ready_busy_n = (busy_cnt != 0) ? 1'b0 : 1'b1;
  always #10 if (busy_cnt != 0) busy_cnt--;
  always @(negedge rd_act) begin
    last_q = out_val;
    if (busy_cnt != 0 || err_mode) tog = ~tog;
  end
  always @(posedge wr_act) wa = i_addr;
  always @(negedge wr_act) begin
    if (i_rst_n === 1'b1) begin
      prog_data = i_dq;
      if (wa[25:16] == FAIL_BLK) err_mode = 1'b1;
      else if (i_wp_n || wa[25:16] != 10'h3ff) begin
        mem[wa] = i_dq;
        busy_cnt = BUSY_NS / 10;
      end
    end
  end
  always @(negedge i_rst_n) begin
    if (busy_cnt != 0) mem[wa] = ~prog_data;
    busy_cnt = 0;
    err_mode = 1'b0;
    tog = 1'b0;
  end
endmodule

/* File: nor_host_ctrl_monitor.sv */
/* Pin-level checks on the flash side of the host controller.
   Assumes it is bound onto nor_host_ctrl and sees only its ports. */
`timescale 1ns/100ps
module nor_host_ctrl_monitor #(
  parameter int unsigned ADDR_W = 26,
  parameter int unsigned DATA_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] o_flash_addr,
  input wire logic o_chip_select_n,
  input wire logic o_output_enable_n,
  input wire logic o_write_strobe_n,
  input wire logic o_hw_reset_n,
  input wire logic [DATA_W-1:0] o_dq_out,
  input wire logic o_dq_oe_n
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_read_we_high: assert property (!o_output_enable_n |->
    o_write_strobe_n && !o_chip_select_n)
    else $error("read cycle with bad strobes");
  a_write_oe_high: assert property (!o_write_strobe_n |->
    o_output_enable_n && !o_chip_select_n && o_hw_reset_n)
    else $error("write cycle with bad strobes");
  a_wr_addr_held: assert property (!o_write_strobe_n |-> $stable(o_flash_addr))
    else $error("address moved during write");
  a_wr_data_held: assert property ($rose(o_write_strobe_n) |->
    !o_dq_oe_n && $stable(o_dq_out))
    else $error("data not held to strobe rise");
  a_strobe_pulse_len: assert property ($fell(o_write_strobe_n) |->
    !o_write_strobe_n [*3])
    else $error("write pulse too short");
  a_drive_oe_high: assert property (!o_dq_oe_n |-> o_output_enable_n)
    else $error("host drives bus with output enable low");
  a_reset_deselect: assert property (!o_hw_reset_n |->
    o_chip_select_n && o_output_enable_n && o_write_strobe_n)
    else $error("strobes active in reset");
  a_reset_pulse_len: assert property ($fell(o_hw_reset_n) |-> !o_hw_reset_n [*5])
    else $error("reset pulse too short");
  a_reset_wait_read: assert property ($rose(o_hw_reset_n) |-> o_chip_select_n [*8])
    else $error("access too soon after reset");
endmodule

/* File: nor_flash_bus_and_polling_status_tb.sv */
/* Self-checking bench: host controller against the flash model.
   Assumes the package, controller, model and monitor are compiled first. */
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module nor_flash_bus_and_polling_status_tb;
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] val;
    logic [5:0] pl;
  } note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  nor_host_pkg::host_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready, done, inv, busy, ce_n, oe_n, we_n, hw_rst_n, wp_n, dq_oe_n, rb_n;
  logic [15:0] rd_data, dq_out, dq_in, dq_flash;
  logic [25:0] addr;
  nor_host_pkg::poll_result_t poll;
  note_t notes[$];
  note_t cur;
  int checks = 0;
  int mismatches = 0;
  int seed = 40916;
  always #10 sys_clk = ~sys_clk;
  assign dq_in = (dq_oe_n === 1'b0) ? dq_out : dq_flash;
  nor_host_ctrl dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_req(req), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .o_rd_data(rd_data), .o_poll(poll), .o_done(done),
    .o_contents_invalid(inv), .o_busy_pin(busy), .o_flash_addr(addr), .o_chip_select_n(ce_n),
    .o_output_enable_n(oe_n), .o_write_strobe_n(we_n), .o_hw_reset_n(hw_rst_n),
    .o_write_protect_n(wp_n), .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_dq_in(dq_in),
    .i_ready_busy_n(rb_n));
  nor_flash_model #(.ACC_NS(15), .BUSY_NS(4000)) flash (.i_addr(addr), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(hw_rst_n), .i_wp_n(wp_n), .i_dq(dq_in),
    .o_dq(dq_flash), .o_ready_busy_n(rb_n));
  function automatic logic [15:0] fill(input logic [25:0] a);
    return a[15:0] ^ {6'h00, a[25:16]};
  endfunction
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic issue(input nor_host_pkg::cmd_op_t c, input logic [25:0] a,
      input logic [15:0] d, input note_t n);
    int k;
    req <= '{op: c, addr: a, data: d};
    req_valid <= 1'b1;
    notes.push_back(n);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    if (req_ready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (done !== 1'b1 && k < 300);
    if (done !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic rd(input logic [25:0] a, input logic [15:0] v);
    issue(nor_host_pkg::CMD_READ, a, 16'h0000, {2'h1, v, 6'h00});
  endtask
  task automatic wr(input logic [25:0] a, input logic [15:0] d);
    issue(nor_host_pkg::CMD_WRITE, a, d, {2'h0, 16'h0000, 6'h00});
  endtask
  task automatic pl(input logic [25:0] a, input logic [15:0] d, input logic [5:0] p);
    // Upper byte reads zero while status shows; true data once the device is done
    issue(nor_host_pkg::CMD_POLL, a, d, {2'h2, (p[5] ? d : 16'h0000), p});
  endtask
  task automatic rs();
    issue(nor_host_pkg::CMD_RESET, 26'h0000000, 16'h0000, {2'h0, 16'h0000, 6'h00});
  endtask
  // Results are judged where they appear, against the oldest note
  always @(posedge sys_clk) begin
    if (done === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.kind == 2'h1) `CHK(rd_data, cur.val)
      if (cur.kind == 2'h2) `CHK(poll, cur.pl)
      if (cur.kind == 2'h2) `CHK(rd_data[15:8], cur.val[15:8])
    end
  end
  initial begin
    logic [25:0] a;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(26'h0000000, fill(26'h0000000));
    rd(26'h3ffffff, fill(26'h3ffffff));
    for (int i = 0; i < 8; i++) begin
      a = 26'($random(seed));
      rd(a, fill(a));
    end
    $display("test random_read done");
    for (int i = 0; i < 17; i++) rd(26'h0123450 + 26'(i), fill(26'h0123450 + 26'(i)));
    $display("test page_read done");
    a = 26'h0200040;
    // Low byte zero so the finished word shows no stray status flags
    wr(a, 16'h5a00);
    pl(a, 16'h5a00, 6'h10);
    `CHK(busy, 1'b1)
    repeat (250) @(posedge sys_clk);
    `CHK(busy, 1'b0)
    pl(a, 16'h5a00, 6'h20);
    rd(a, 16'h5a00);
    $display("test program_poll done");
    a = {10'h155, 16'h0008};
    wr(a, 16'h00ff);
    pl(a, 16'h00ff, 6'h14);
    rs();
    `CHK(inv, 1'b0)
    rd(a, fill(a));
    $display("test program_error done");
    wr(26'h0300000, 16'h1234);
    repeat (10) @(posedge sys_clk);
    rs();
    `CHK(inv, 1'b1)
    rd(26'h0300001, fill(26'h0300001));
    $display("test reset_abort done");
    close_out();
  end
endmodule
bind nor_host_ctrl nor_host_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_flash_addr(o_flash_addr),
  .o_chip_select_n(o_chip_select_n), .o_output_enable_n(o_output_enable_n),
  .o_write_strobe_n(o_write_strobe_n), .o_hw_reset_n(o_hw_reset_n), .o_dq_out(o_dq_out),
  .o_dq_oe_n(o_dq_oe_n));
